// ---- hw/sjt_tap_regs.svh ----
// constants of the sram boundary-scan test access port
`ifndef SJT_TAP_REGS_SVH
`define SJT_TAP_REGS_SVH

`define SJT_IR_WIDTH        3
`define SJT_BYPASS_WIDTH    1
`define SJT_ID_WIDTH        32
`define SJT_BSR_LENGTH      136

`define SJT_ID_VERSION_MSB  31
`define SJT_ID_VERSION_LSB  29
`define SJT_ID_PART_MSB     28
`define SJT_ID_PART_LSB     12
`define SJT_ID_MANUF_MSB    11
`define SJT_ID_MANUF_LSB    1
`define SJT_ID_PRESENT_BIT  0

`define SJT_CODE_EXTEST     3'h0
`define SJT_CODE_IDCODE     3'h1
`define SJT_CODE_SAMPLE_Z   3'h2
`define SJT_CODE_RSVD_3     3'h3
`define SJT_CODE_SAMPLE     3'h4
`define SJT_CODE_RSVD_5     3'h5
`define SJT_CODE_RSVD_6     3'h6
`define SJT_CODE_BYPASS     3'h7

`define SJT_IR_CAPTURE      3'h1
`define SJT_IR_RESET        3'h1

`define SJT_CELL_PORT_B_OE  49
`define SJT_CELL_PORT_A_OE  50

`endif

// ---- hw/sjt_tap_pkg.sv ----
// types of the sram boundary-scan test access port
`include "sjt_tap_regs.svh"

package sjt_tap_pkg;

    typedef enum logic [15:0] {
        SJT_TLR        = 16'h0001,
        SJT_RTI        = 16'h0002,
        SJT_SEL_DR     = 16'h0004,
        SJT_CAP_DR     = 16'h0008,
        SJT_SHIFT_DR   = 16'h0010,
        SJT_EXIT1_DR   = 16'h0020,
        SJT_PAUSE_DR   = 16'h0040,
        SJT_EXIT2_DR   = 16'h0080,
        SJT_UPD_DR     = 16'h0100,
        SJT_SEL_IR     = 16'h0200,
        SJT_CAP_IR     = 16'h0400,
        SJT_SHIFT_IR   = 16'h0800,
        SJT_EXIT1_IR   = 16'h1000,
        SJT_PAUSE_IR   = 16'h2000,
        SJT_EXIT2_IR   = 16'h4000,
        SJT_UPD_IR     = 16'h8000
    } sjt_state_t;

    typedef enum logic [`SJT_IR_WIDTH-1:0] {
        SJT_EXTEST     = `SJT_CODE_EXTEST,
        SJT_IDCODE     = `SJT_CODE_IDCODE,
        SJT_SAMPLE_Z   = `SJT_CODE_SAMPLE_Z,
        SJT_RSVD_3     = `SJT_CODE_RSVD_3,
        SJT_SAMPLE     = `SJT_CODE_SAMPLE,
        SJT_RSVD_5     = `SJT_CODE_RSVD_5,
        SJT_RSVD_6     = `SJT_CODE_RSVD_6,
        SJT_BYPASS     = `SJT_CODE_BYPASS
    } sjt_instr_t;

endpackage

// ---- hw/sjt_tap.sv ----
// boundary-scan test access port of a dual-port sram, oversampling tck
//
// Contract
// - instruction 3, bypass 1, boundary 136 cells
// - identification 32 bits, bit zero reads one
// - id bits 31:29 hold fixed version
// - id bits 28:12 hold fixed part code
// - id bits 11:1 hold fixed maker code
// - code 000 is external test, captures ring
// - code 001 selects identification, memory untouched
// - code 010 captures, selects boundary, outputs high-z
// - code 100 captures, selects boundary, memory untouched
// - code 111 selects bypass, memory untouched
// - cells 49/50 internal: port b, port a enables
// - external test: enable cells gate outputs, reset low
// - external test drives preload data, enables ports
`timescale 1ns/1ps
`include "sjt_tap_regs.svh"

module sjt_tap #(
    parameter int                  BSR_LENGTH = `SJT_BSR_LENGTH,
    parameter logic [2:0]          ID_VERSION = 3'h2,       // arbitrary value
    parameter logic [16:0]         ID_PART    = 17'h0ABCD,  // arbitrary value
    parameter logic [10:0]         ID_MANUF   = 11'h155     // arbitrary value
) (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  tck,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    output logic                       tdo,
    output logic                       tdo_oe,
    input  wire logic [BSR_LENGTH-1:0] pin_sample,
    input  wire logic                  core_port_a_oe,
    input  wire logic                  core_port_b_oe,
    output logic [BSR_LENGTH-1:0]      boundary_out,
    output logic                       boundary_drive,
    output logic                       port_a_drive_enable,
    output logic                       port_b_drive_enable,
    output logic [`SJT_IR_WIDTH-1:0]   instruction
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and tck edge detection

    logic [2:0]            sync1;
    logic [2:0]            sync2;
    logic                  tck_prev;
    logic [BSR_LENGTH-1:0] pin_sync1;
    logic [BSR_LENGTH-1:0] pin_sync2;
    logic                  tck_rise;
    logic                  tck_fall;
    logic                  tms_s;
    logic                  tdi_s;

    // tck is only a sampled pin here, so each tck phase must span several clocks
    always_ff @(posedge clock) begin
        sync1     <= {tck, tms, tdi};
        sync2     <= sync1;
        pin_sync1 <= pin_sample;
        pin_sync2 <= pin_sync1;
        tck_prev  <= reset ? 1'b0 : sync2[2];
    end

    always_comb begin
        tck_rise = sync2[2] & ~tck_prev;
        tck_fall = ~sync2[2] & tck_prev;
        tms_s    = sync2[1];
        tdi_s    = sync2[0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // instruction decoding, shared by the scan path and the pin control

    // reserved codes match nothing here, so they end up on the one-bit path
    function automatic logic selects_boundary(input sjt_tap_pkg::sjt_instr_t code);
        logic hit;
        hit = 1'b0;
        if (code == sjt_tap_pkg::SJT_EXTEST) begin
            hit = 1'b1;
        end else if (code == sjt_tap_pkg::SJT_SAMPLE_Z) begin
            hit = 1'b1;
        end else if (code == sjt_tap_pkg::SJT_SAMPLE) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    function automatic logic selects_id(input sjt_tap_pkg::sjt_instr_t code);
        return code == sjt_tap_pkg::SJT_IDCODE;
    endfunction

    // only external test hands the pins and the enable cells to the chain
    function automatic logic drives_pins(input sjt_tap_pkg::sjt_instr_t code);
        return code == sjt_tap_pkg::SJT_EXTEST;
    endfunction

    // sample-z keeps the chain but parks both memory ports
    function automatic logic forces_high_z(input sjt_tap_pkg::sjt_instr_t code);
        return code == sjt_tap_pkg::SJT_SAMPLE_Z;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // controller and scan registers

    sjt_tap_pkg::sjt_state_t      state;
    sjt_tap_pkg::sjt_state_t      next_state;
    sjt_tap_pkg::sjt_instr_t      ir;
    sjt_tap_pkg::sjt_instr_t      next_ir;
    logic [`SJT_IR_WIDTH-1:0]     ir_shift;
    logic [`SJT_IR_WIDTH-1:0]     next_ir_shift;
    logic [BSR_LENGTH-1:0]        dr_shift;
    logic [BSR_LENGTH-1:0]        next_dr_shift;
    logic [BSR_LENGTH-1:0]        preload;
    logic [BSR_LENGTH-1:0]        next_preload;
    logic                         next_tdo;
    logic                         next_tdo_oe;
    logic [`SJT_ID_WIDTH-1:0]     id_word;
    logic                         sel_bsr;
    logic                         sel_id;

    always_comb begin
        // the fields are parameters so each width variant carries its own part code
        id_word = {ID_VERSION, ID_PART, ID_MANUF, 1'b1};
        // reserved codes fall back to bypass; the tester must not use them
        sel_bsr = selects_boundary(ir);
        sel_id  = selects_id(ir);
    end

    always_comb begin
        next_state = state;
        if (tck_rise) begin
            case (state)
                sjt_tap_pkg::SJT_TLR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_TLR : sjt_tap_pkg::SJT_RTI;
                end
                sjt_tap_pkg::SJT_RTI: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_SEL_DR : sjt_tap_pkg::SJT_RTI;
                end
                sjt_tap_pkg::SJT_SEL_DR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_SEL_IR : sjt_tap_pkg::SJT_CAP_DR;
                end
                sjt_tap_pkg::SJT_CAP_DR, sjt_tap_pkg::SJT_SHIFT_DR,
                sjt_tap_pkg::SJT_EXIT2_DR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_EXIT1_DR
                                       : sjt_tap_pkg::SJT_SHIFT_DR;
                    if (state == sjt_tap_pkg::SJT_EXIT2_DR && tms_s) begin
                        next_state = sjt_tap_pkg::SJT_UPD_DR;
                    end
                end
                sjt_tap_pkg::SJT_EXIT1_DR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_UPD_DR : sjt_tap_pkg::SJT_PAUSE_DR;
                end
                sjt_tap_pkg::SJT_PAUSE_DR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_EXIT2_DR
                                       : sjt_tap_pkg::SJT_PAUSE_DR;
                end
                sjt_tap_pkg::SJT_UPD_DR, sjt_tap_pkg::SJT_UPD_IR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_SEL_DR : sjt_tap_pkg::SJT_RTI;
                end
                sjt_tap_pkg::SJT_SEL_IR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_TLR : sjt_tap_pkg::SJT_CAP_IR;
                end
                sjt_tap_pkg::SJT_CAP_IR, sjt_tap_pkg::SJT_SHIFT_IR,
                sjt_tap_pkg::SJT_EXIT2_IR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_EXIT1_IR
                                       : sjt_tap_pkg::SJT_SHIFT_IR;
                    if (state == sjt_tap_pkg::SJT_EXIT2_IR && tms_s) begin
                        next_state = sjt_tap_pkg::SJT_UPD_IR;
                    end
                end
                sjt_tap_pkg::SJT_EXIT1_IR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_UPD_IR : sjt_tap_pkg::SJT_PAUSE_IR;
                end
                sjt_tap_pkg::SJT_PAUSE_IR: begin
                    next_state = tms_s ? sjt_tap_pkg::SJT_EXIT2_IR
                                       : sjt_tap_pkg::SJT_PAUSE_IR;
                end
                default: begin
                    next_state = sjt_tap_pkg::SJT_TLR;
                end
            endcase
        end
    end

    always_comb begin
        next_ir       = ir;
        next_ir_shift = ir_shift;
        next_dr_shift = dr_shift;
        next_preload  = preload;
        // applied every clock in this state, so a tester that parks tck here still resets
        if (state == sjt_tap_pkg::SJT_TLR) begin
            next_ir = sjt_tap_pkg::sjt_instr_t'(`SJT_IR_RESET);
            next_preload[`SJT_CELL_PORT_B_OE] = 1'b0;
            next_preload[`SJT_CELL_PORT_A_OE] = 1'b0;
        end

        if (tck_rise) begin
            case (state)
                sjt_tap_pkg::SJT_CAP_IR: begin
                    next_ir_shift = `SJT_IR_CAPTURE;
                end
                sjt_tap_pkg::SJT_SHIFT_IR: begin
                    next_ir_shift = {tdi_s, ir_shift[`SJT_IR_WIDTH-1:1]};
                end
                sjt_tap_pkg::SJT_UPD_IR: begin
                    next_ir = sjt_tap_pkg::sjt_instr_t'(ir_shift);
                end
                sjt_tap_pkg::SJT_CAP_DR: begin
                    if (sel_bsr) begin
                        next_dr_shift = pin_sync2;
                    end else if (sel_id) begin
                        next_dr_shift = '0;
                        next_dr_shift[`SJT_ID_WIDTH-1:0] = id_word;
                    end else begin
                        next_dr_shift = '0;
                    end
                end
                sjt_tap_pkg::SJT_SHIFT_DR: begin
                    // one shared chain; the entry point sets the selected length
                    if (sel_bsr) begin
                        next_dr_shift = {tdi_s, dr_shift[BSR_LENGTH-1:1]};
                    end else if (sel_id) begin
                        next_dr_shift[`SJT_ID_WIDTH-1:0] =
                            {tdi_s, dr_shift[`SJT_ID_WIDTH-1:1]};
                    end else begin
                        next_dr_shift[0] = tdi_s;
                    end
                end
                sjt_tap_pkg::SJT_UPD_DR: begin
                    if (sel_bsr) begin
                        next_preload = dr_shift;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_tdo    = tdo;
        next_tdo_oe = tdo_oe;
        // tdo changes on the falling tck edge so the tester samples a settled bit
        if (tck_fall) begin
            next_tdo_oe = (state == sjt_tap_pkg::SJT_SHIFT_DR) ||
                          (state == sjt_tap_pkg::SJT_SHIFT_IR);
            if (state == sjt_tap_pkg::SJT_SHIFT_IR) begin
                next_tdo = ir_shift[0];
            end else if (state == sjt_tap_pkg::SJT_SHIFT_DR) begin
                next_tdo = dr_shift[0];
            end else begin
                next_tdo = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state    <= sjt_tap_pkg::SJT_TLR;
            ir       <= sjt_tap_pkg::sjt_instr_t'(`SJT_IR_RESET);
            ir_shift <= '0;
            dr_shift <= '0;
            preload  <= '0;
            tdo      <= 1'b0;
            tdo_oe   <= 1'b0;
        end else begin
            state    <= next_state;
            ir       <= next_ir;
            ir_shift <= next_ir_shift;
            dr_shift <= next_dr_shift;
            preload  <= next_preload;
            tdo      <= next_tdo;
            tdo_oe   <= next_tdo_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin control

    always_comb begin
        instruction    = ir;
        boundary_out   = preload;
        boundary_drive = drives_pins(ir);
        // reserved codes land in the last branch and leave the memory alone
        if (drives_pins(ir)) begin
            port_a_drive_enable = preload[`SJT_CELL_PORT_A_OE];
            port_b_drive_enable = preload[`SJT_CELL_PORT_B_OE];
        end else if (forces_high_z(ir)) begin
            port_a_drive_enable = 1'b0;
            port_b_drive_enable = 1'b0;
        end else begin
            port_a_drive_enable = core_port_a_oe;
            port_b_drive_enable = core_port_b_oe;
        end
    end

endmodule

// ---- test/sjt_tap_monitor.sv ----
// assertions on the outputs of the sram test access port
`timescale 1ns/1ps
`include "sjt_tap_regs.svh"

module sjt_tap_monitor #(
    parameter int BSR_LENGTH = 136
) (
    input wire logic                     clock,
    input wire logic                     reset,
    input wire logic                     tdo,
    input wire logic                     tdo_oe,
    input wire logic                     core_port_a_oe,
    input wire logic                     core_port_b_oe,
    input wire logic [BSR_LENGTH-1:0]    boundary_out,
    input wire logic                     boundary_drive,
    input wire logic                     port_a_drive_enable,
    input wire logic                     port_b_drive_enable,
    input wire logic [`SJT_IR_WIDTH-1:0] instruction
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    sequence s_extest_held;
        instruction == 3'h0 ##1 instruction == 3'h0;
    endsequence
    sequence s_other_held;
        instruction != 3'h0 ##1 instruction != 3'h0;
    endsequence
    property p_drive_on; s_extest_held |-> boundary_drive; endproperty
    property p_drive_off; s_other_held |-> !boundary_drive; endproperty
    property p_cell_a;
        boundary_drive |-> port_a_drive_enable == boundary_out[`SJT_CELL_PORT_A_OE];
    endproperty
    property p_cell_b;
        boundary_drive |-> port_b_drive_enable == boundary_out[`SJT_CELL_PORT_B_OE];
    endproperty
    property p_hiz; instruction == 3'h2 |-> !port_a_drive_enable && !port_b_drive_enable;
    endproperty
    property p_pass; instruction inside {3'h1, 3'h4, 3'h7}
        |-> port_a_drive_enable == core_port_a_oe && port_b_drive_enable == core_port_b_oe;
    endproperty
    property p_tdo_idle; !tdo_oe |-> !tdo; endproperty
    property p_ir_quiet; $changed(instruction) |-> !tdo_oe; endproperty
    // while identification or bypass is held, preload bits 135:51 above the enable cells must not move
    property p_keep; $past(instruction) inside {3'h1, 3'h7} && instruction inside {3'h1, 3'h7}
        |-> $stable(boundary_out[BSR_LENGTH-1:51]);
    endproperty
    a_drive_on: assert property (p_drive_on) else $error("drive off");
    a_drive_off: assert property (p_drive_off) else $error("drive on");
    a_cell_a: assert property (p_cell_a) else $error("port a enable");
    a_cell_b: assert property (p_cell_b) else $error("port b enable");
    a_hiz: assert property (p_hiz) else $error("not high z");
    a_pass: assert property (p_pass) else $error("enable not passed");
    a_tdo_idle: assert property (p_tdo_idle) else $error("tdo not idle");
    a_ir_quiet: assert property (p_ir_quiet) else $error("ir change in shift");
    a_keep: assert property (p_keep) else $error("preload moved");
endmodule

bind sjt_tap sjt_tap_monitor #(.BSR_LENGTH(BSR_LENGTH)) sjt_tap_monitor_i (
    .clock(clock), .reset(reset), .tdo(tdo), .tdo_oe(tdo_oe),
    .core_port_a_oe(core_port_a_oe), .core_port_b_oe(core_port_b_oe),
    .boundary_out(boundary_out), .boundary_drive(boundary_drive),
    .port_a_drive_enable(port_a_drive_enable), .port_b_drive_enable(port_b_drive_enable),
    .instruction(instruction)
);

// ---- test/sjt_tester.sv ----
// tester model: drives test clock, mode and data, collects tdo
`timescale 1ns/1ps

module sjt_tester (
    output logic     tck,
    output logic     tms,
    output logic     tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    ////////////////////////////////////////
    // tck rests low between tasks; tdo is read just before the shifting rise
    task automatic step(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        #62.5;
        q = tdo;
        tck <= 1'b1;
        #62.5;
        tck <= 1'b0;
    endtask

    task automatic walk(input logic [5:0] ms, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            step(ms[i], ~tdi, q);
        end
    endtask

    task automatic shift(input int n, input logic [135:0] din, output logic [135:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        walk(6'h01, 2);
    endtask

    task automatic reset_tap();
        walk(6'h1F, 6);
    endtask

    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        logic [135:0] o;
        walk(6'h03, 4);
        shift(3, {133'h0, code}, o);
        cap = o[2:0];
    endtask

    task automatic scan_dr(input int n, input logic [135:0] din, output logic [135:0] dout);
        walk(6'h01, 3);
        shift(n, din, dout);
    endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench of the sram test access port
`timescale 1ns/1ps

module tb;
    localparam logic [2:0]  VER   = 3'h5;     // arbitrary value
    localparam logic [16:0] PART  = 17'h1C3A5; // arbitrary value
    localparam logic [10:0] MANUF = 11'h2B6;  // arbitrary value
    logic         clock;
    logic         reset;
    logic         tck, tms, tdi, tdo, tdo_oe;
    logic [135:0] pin_sample;
    logic         core_a, core_b, en_a, en_b;
    logic [135:0] boundary_out;
    logic         boundary_drive;
    logic [2:0]   instruction;
    logic [135:0] pre;
    int           miscompares;
    int           n_tests;

    sjt_tap #(.ID_VERSION(VER), .ID_PART(PART), .ID_MANUF(MANUF)) sjt_tap_i (
        .clock(clock), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .pin_sample(pin_sample), .core_port_a_oe(core_a),
        .core_port_b_oe(core_b), .boundary_out(boundary_out), .boundary_drive(boundary_drive),
        .port_a_drive_enable(en_a), .port_b_drive_enable(en_b), .instruction(instruction)
    );
    sjt_tester sjt_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    ////////////////////////////////////////
    function automatic logic [31:0] id_word();
        return {VER, PART, MANUF, 1'b1};
    endfunction

    function automatic logic [1:0] exp_en(input logic [2:0] c, input logic [1:0] cells,
                                          input logic [1:0] core);
        if (c == 3'h0) return cells;
        if (c == 3'h2) return 2'b00;
        return core;
    endfunction

    task automatic check(input string what, input logic [135:0] exp, input logic [135:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        #400000;
        miscompares++;
        test_done();
    end

    initial begin
        logic [159:0] rnd;
        logic [135:0] din, dout, exp;
        logic [2:0]   cap;
        logic [2:0]   codes [5];
        int           n;
        codes = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h7};
        reset = 1'b1;
        {core_a, core_b} = 2'b00;
        pin_sample = '0;
        pre = '0;
        miscompares = 0;
        n_tests = 0;
        void'($urandom(68));
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        repeat (4) @(negedge clock);
        check("reset instruction", 3'h1, instruction);
        check("reset preload", '0, boundary_out);
        check("reset drive", '0, {tdo_oe, boundary_drive});
        // the controller rests in test-logic-reset; this walk leaves it in run-test-idle
        sjt_tester_i.reset_tap();
        for (int r = 0; r < 2; r++) begin
            foreach (codes[k]) begin
                rnd = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
                din = rnd[159:24];
                din[50:49] = r ? 2'b11 : 2'b10;
                @(posedge clock);
                pin_sample <= rnd[135:0];
                core_a <= rnd[0];
                core_b <= rnd[1];
                sjt_tester_i.load_ir(codes[k], cap);
                check("ir capture", 3'h1, cap);
                check("instruction", codes[k], instruction);
                n = codes[k] == 3'h1 ? 32 : codes[k] == 3'h7 ? 2 : 136;
                sjt_tester_i.scan_dr(n, din, dout);
                exp = codes[k] == 3'h1 ? id_word()
                    : codes[k] == 3'h7 ? {din[0], 1'b0} : rnd[135:0];
                check("scan out", exp, dout);
                if (codes[k] inside {3'h0, 3'h2, 3'h4}) pre = din;
                @(negedge clock);
                check("preload", pre, boundary_out);
                check("drive", codes[k] == 3'h0, boundary_drive);
                check("enables", exp_en(codes[k], pre[50:49], {core_a, core_b}),
                      {en_a, en_b});
                check("tdo idle", 2'b00, {tdo_oe, tdo});
                $display("test code %0d round %0d done", codes[k], r);
            end
        end
        sjt_tester_i.reset_tap();
        @(negedge clock);
        check("tlr instruction", 3'h1, instruction);
        check("tlr cells", 2'b00, boundary_out[50:49]);
        $display("test logic reset done");
        test_done();
    end
endmodule
